//--- hw/defrost_pkg.sv
package defrost_pkg;
   // Board clock
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned CLK_PERIOD_NS = 50;
   // Test mode speeds every timing up by this factor
   localparam int unsigned TEST_SPEEDUP = 260;
   // One fast tick is the unit of all timing; cycles rounded down
   localparam int unsigned FAST_TICK_CYC = CLK_HZ / TEST_SPEEDUP;
   // Fast ticks per one-second slow tick
   localparam logic [8:0] SLOW_TICK_DIV = 9'(TEST_SPEEDUP);
   // Interval lengths, in minutes as printed, and in seconds
   localparam int unsigned INTERVAL_A_MIN = 30;
   localparam int unsigned INTERVAL_B_MIN = 60;
   localparam int unsigned INTERVAL_C_MIN = 90;
   localparam logic [12:0] INTERVAL_A_S = 13'(INTERVAL_A_MIN * 60);
   localparam logic [12:0] INTERVAL_B_S = 13'(INTERVAL_B_MIN * 60);
   localparam logic [12:0] INTERVAL_C_S = 13'(INTERVAL_C_MIN * 60);
   // Defrost override
   localparam int unsigned OVERRIDE_MIN = 10;
   localparam logic [9:0] OVERRIDE_S = 10'(OVERRIDE_MIN * 60);
   // Jumper codes
   localparam logic [1:0] SEL_30 = 2'h0;
   localparam logic [1:0] SEL_60 = 2'h1;
   localparam logic [1:0] SEL_90 = 2'h2;
   // Reset values
   localparam logic [16:0] PRESCALE_RST = 17'h00000;
   localparam logic [8:0] SLOW_RST = 9'h000;
   localparam logic [12:0] INTERVAL_RST = 13'h0000;
   localparam logic [9:0] DEFROST_RST = 10'h000;
   // Controller states
   typedef enum logic [1:0] {
      ST_ACCUM = 2'b01,
      ST_DEFROST = 2'b10
   } defrost_state_t;
endpackage : defrost_pkg

//--- hw/heat_pump_defrost_timer.sv
`timescale 1ns/1ps
module heat_pump_defrost_timer #(
   parameter int unsigned FAST_TICK_CYC = defrost_pkg::FAST_TICK_CYC
) (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic coil_switch_input_in,
   input wire logic heat_call_in,
   input wire logic test_short_in,
   input wire logic [1:0] jumper_sel_in,
   output logic reversing_valve_out,
   output logic outdoor_fan_output_out,
   output logic supp_heat_out
);

   // Interval length in seconds for a jumper code; an unused code falls back to the longest
   function automatic logic [12:0] interval_limit(input logic [1:0] sel);
      logic [12:0] lim;
      lim = defrost_pkg::INTERVAL_C_S;
      if (sel == defrost_pkg::SEL_30) begin
         lim = defrost_pkg::INTERVAL_A_S;
      end else if (sel == defrost_pkg::SEL_60) begin
         lim = defrost_pkg::INTERVAL_B_S;
      end else if (sel == defrost_pkg::SEL_90) begin
         lim = defrost_pkg::INTERVAL_C_S;
      end
      return lim;
   endfunction : interval_limit

   // One-hot state test, shared by the cycle control and the relay outputs
   function automatic logic is_defrost(input defrost_pkg::defrost_state_t st);
      return (st == defrost_pkg::ST_DEFROST);
   endfunction : is_defrost

   localparam logic [16:0] FAST_LAST = 17'(FAST_TICK_CYC - 1);

   // Counters, state and relay flip-flops
   logic [16:0] prescale_q;
   logic [16:0] prescale_d;
   logic [8:0] slow_q;
   logic [8:0] slow_d;
   logic [12:0] interval_q;
   logic [12:0] interval_d;
   logic [9:0] defrost_q;
   logic [9:0] defrost_d;
   defrost_pkg::defrost_state_t state_q;
   defrost_pkg::defrost_state_t state_d;
   logic valve_q;
   logic fan_q;
   logic heat_q;

   // Decoded terms, one named wire each
   wire fast_tick;
   wire slow_tick;
   wire step;
   wire accum_ok;
   wire interval_done;
   wire in_defrost;
   wire start_defrost;
   wire end_defrost;
   wire [12:0] limit;
   // Counter increments, defrost end causes and the relays' next state
   wire [12:0] interval_inc;
   wire [9:0] defrost_inc;
   wire coil_open;
   wire override_hit;
   wire defrost_next;

   // Single prescaler; the one-second tick is carved from the same fast tick
   assign fast_tick = (prescale_q == FAST_LAST);
   assign prescale_d = fast_tick ? defrost_pkg::PRESCALE_RST : prescale_q + 17'h00001;

   // Second divider counts fast ticks, so test and normal timing share one source
   assign slow_tick = fast_tick && (slow_q == defrost_pkg::SLOW_TICK_DIV - 9'h001);
   assign slow_d = slow_tick ? defrost_pkg::SLOW_RST :
                   (fast_tick ? slow_q + 9'h001 : slow_q);

   // Test short swaps the one-second step for the fast tick, so the interval and defrost counts run 260x
   assign step = test_short_in ? fast_tick : slow_tick;

   // Accumulation and cycle control
   assign limit = interval_limit(jumper_sel_in);
   assign accum_ok = coil_switch_input_in && heat_call_in;
   assign interval_done = (interval_q >= limit);
   assign in_defrost = is_defrost(state_q);
   // Jumper moved below the count still starts at once: >= rather than ==
   assign start_defrost = !in_defrost && interval_done && !coil_open;
   // Either cause ends the cycle; the override is the fallback for a stuck-closed switch
   assign end_defrost = in_defrost && (coil_open || override_hit);

   // End causes and counter increments
   assign coil_open = !coil_switch_input_in;
   assign override_hit = (defrost_q >= defrost_pkg::OVERRIDE_S);
   // Both counts are capped by the control logic, so the adders never wrap
   assign interval_inc = interval_q + 13'h0001;
   assign defrost_inc = defrost_q + 10'h001;

   // Next-state and counter selection
   always_comb begin
      state_d = state_q;
      interval_d = interval_q;
      defrost_d = defrost_q;
      unique case (state_q)
         defrost_pkg::ST_ACCUM: begin
            if (start_defrost) begin
               state_d = defrost_pkg::ST_DEFROST;
               defrost_d = defrost_pkg::DEFROST_RST;
            end else if (accum_ok && step && !interval_done) begin
               interval_d = interval_inc;
            end
         end
         defrost_pkg::ST_DEFROST: begin
            if (end_defrost) begin
               state_d = defrost_pkg::ST_ACCUM;
               interval_d = defrost_pkg::INTERVAL_RST;
               defrost_d = defrost_pkg::DEFROST_RST;
            end else if (step) begin
               defrost_d = defrost_inc;
            end
         end
         default: begin
            state_d = defrost_pkg::ST_ACCUM;
            interval_d = defrost_pkg::INTERVAL_RST;
            defrost_d = defrost_pkg::DEFROST_RST;
         end
      endcase
   end

   // Prescaler runs free through defrost, so its phase never depends on the cycle
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         prescale_q <= defrost_pkg::PRESCALE_RST;
      end else begin
         prescale_q <= prescale_d;
      end
   end

   // Second divider
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         slow_q <= defrost_pkg::SLOW_RST;
      end else begin
         slow_q <= slow_d;
      end
   end

   // Accumulated interval time
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         interval_q <= defrost_pkg::INTERVAL_RST;
      end else begin
         interval_q <= interval_d;
      end
   end

   // Defrost duration, in steps
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         defrost_q <= defrost_pkg::DEFROST_RST;
      end else begin
         defrost_q <= defrost_d;
      end
   end

   // Controller state
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         state_q <= defrost_pkg::ST_ACCUM;
      end else begin
         state_q <= state_d;
      end
   end

   // Relays follow the next state so the valve moves on the same edge as the state
   assign defrost_next = is_defrost(state_d);

   // Reversing valve
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         valve_q <= 1'b0;
      end else begin
         valve_q <= defrost_next;
      end
   end

   // Fan is cut in defrost so the coil warms faster; also off with no heat call
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         fan_q <= 1'b0;
      end else begin
         fan_q <= heat_call_in && !defrost_next;
      end
   end

   // Supplementary heat makes up for the cold air the reversed cycle sends indoors
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         heat_q <= 1'b0;
      end else begin
         heat_q <= defrost_next;
      end
   end

   // Pins come straight from the relay flip-flops
   assign reversing_valve_out = valve_q;
   assign outdoor_fan_output_out = fan_q;
   assign supp_heat_out = heat_q;

endmodule : heat_pump_defrost_timer

//--- tb/defrost_sva.sv
`timescale 1ns/1ps
module defrost_sva (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic coil_switch_input_in,
   input wire logic heat_call_in,
   input wire logic reversing_valve_out,
   input wire logic outdoor_fan_output_out,
   input wire logic supp_heat_out
);
   default clocking @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   supp_same_a: assert property (reversing_valve_out == supp_heat_out)
      else $error("supp heat");
   fan_off_a: assert property (reversing_valve_out |-> !outdoor_fan_output_out)
      else $error("fan on");
   fan_follow_a: assert property ($past(rst_n_in) |=> outdoor_fan_output_out ==
      ($past(heat_call_in) && !reversing_valve_out)) else $error("fan");
   coil_end_a: assert property (reversing_valve_out && !coil_switch_input_in |=>
      !reversing_valve_out) else $error("no end");
   start_closed_a: assert property ($rose(reversing_valve_out) |->
      $past(coil_switch_input_in)) else $error("coil open");
   valve_hold_a: assert property ($rose(reversing_valve_out) && coil_switch_input_in
      |=> reversing_valve_out) else $error("valve drop");
   gap_min_a: assert property ($fell(reversing_valve_out) |->
      !reversing_valve_out [*8]) else $error("gap");
   reset_out_a: assert property (disable iff (1'b0) !rst_n_in |=>
      !(reversing_valve_out || supp_heat_out)) else $error("reset");
   cover property ($rose(reversing_valve_out));
   cover property ($fell(reversing_valve_out) && !coil_switch_input_in);
   cover property ($fell(reversing_valve_out) && coil_switch_input_in);
endmodule : defrost_sva
bind heat_pump_defrost_timer defrost_sva chk (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
   .coil_switch_input_in(coil_switch_input_in), .heat_call_in(heat_call_in),
   .reversing_valve_out(reversing_valve_out),
   .outdoor_fan_output_out(outdoor_fan_output_out),
   .supp_heat_out(supp_heat_out));

//--- tb/coil_model.sv
`timescale 1ns/1ps
module coil_model (
   input wire logic clk_in,
   input wire logic valve_in,
   input wire logic warm_in,
   input wire logic [9:0] open_in,
   output logic coil_out = 1'b1
);
   int n_q = 0;
   // Coil thaws open after open_in reversed cycles; 0 keeps it shut; warm_in holds it open
   always @(posedge clk_in) begin
      n_q <= valve_in ? n_q + 1 : 0;
      coil_out <= !(warm_in || (valve_in && open_in != 0 && n_q >= open_in));
   end
endmodule : coil_model

//--- tb/heat_pump_defrost_timer_tb.sv
`timescale 1ns/1ps
module heat_pump_defrost_timer_tb;
   localparam int FT = 2;
   logic clk = 1'b0, rst_n = 1'b0, heat = 1'b1, test = 1'b1, pv = 1'b0, warm = 1'b0;
   logic [1:0] jmp = 2'h0;
   logic [9:0] k = 10'h000;
   logic coil, valve, fan, supp;
   int n_mismatch = 0, n_tests = 0, cyc = 0, mark = 0, seed = 32'h9ca3, h, r, e;
   int exp_q[$];
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
   $display("CHECK FAILED %0t phase", $time); end end
   heat_pump_defrost_timer #(.FAST_TICK_CYC(FT)) uut (.ref_clk_in(clk), .rst_n_in(rst_n),
      .coil_switch_input_in(coil), .heat_call_in(heat), .test_short_in(test),
      .jumper_sel_in(jmp), .reversing_valve_out(valve), .outdoor_fan_output_out(fan),
      .supp_heat_out(supp));
   coil_model partner (.clk_in(clk), .valve_in(valve), .warm_in(warm), .open_in(k),
      .coil_out(coil));
   initial forever #25 clk = ~clk;
   // Each valve edge ends a phase; its length must match the oldest note
   always @(posedge clk) begin
      cyc <= cyc + 1;
      pv <= valve;
      if (!rst_n || valve !== pv) mark <= cyc;
      if (rst_n && valve !== pv) begin
         e = exp_q.size() ? exp_q.pop_front() : 0;
         `CHK((cyc - mark - e) * (cyc - mark - e) < 100, 1'b1)
         `CHK(supp, valve)
         `CHK(fan, !valve)
      end
   end
   task automatic wait_valve(input logic v);
      int i;
      for (i = 0; i < 20000 && valve !== v; i++) @(negedge clk);
      if (i == 20000) begin
         n_mismatch++;
         complete_run();
      end else @(posedge clk);
   endtask : wait_valve
   task automatic complete_run();
      $display("mismatches %0d tests %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run
   // All jumper codes; odd rounds pause on a warm coil, release the short, thaw early
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      for (int j = 0; j < 4; j++) begin
         h = 40 + ($random(seed) & 63);
         r = j[0] ? 60 + ($random(seed) & 127) : 0;
         jmp <= j[1:0];
         k <= r[9:0];
         exp_q.push_back((j == 0 ? 1800 : j == 1 ? 3600 : 5400) * FT + h);
         exp_q.push_back(r ? r + 2 : 600 * FT);
         heat <= j[0];
         warm <= j[0];
         repeat (h) @(posedge clk);
         heat <= 1'b1;
         warm <= 1'b0;
         wait_valve(1'b1);
         test <= !j[0];
         wait_valve(1'b0);
         test <= 1'b1;
      end
      complete_run();
   end
endmodule : heat_pump_defrost_timer_tb
